// ===== hw/ucr_usart_control_regs.sv
// ucr_usart_control_regs: control register bank, interrupt gating and line steering
//
// Overview of operation
// - break wait bit enables the wait-for-break feature when one, disables when zero
// - bit 7 enables receive-complete request while receive-complete flag is set
// - bit 6 enables transmit-complete request while transmit-complete flag is set
// - bit 5 enables data-register-empty request while that flag is set
// - bit 4 enables receive-start request while receive-start flag is set
// - loop-back feeds receiver from transmit line (tx_line, not the pin) and disconnects receive pin
// - bit 2 enables auto-baud error request while bad sync field flag set
// - first control register bit 0 selects RS-485 line operation
// - second control register bit 7 switches the receiver on
// - second control register bit 6 switches the transmitter on
// - second control register bit 4 enables start-of-frame detection
// - second control register bit 3 selects open-drain single-wire output
// - bits 2:1 select normal, double speed, generic or LIN auto-baud receiver
// - second control register bit 0 enables multiprocessor mode
// - frame register holds mode, parity, stop, size fields, resets to 0x03
// - mode field: asynchronous, synchronous, infrared, host SPI
// - host SPI mode code switches frame register to its SPI field layout
// - size codes give 5 to 8 bits, nine bits low or high first
// - data-register-empty set while transmit data empty, cleared once loaded
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module ucr_usart_control_regs #(
   parameter int ADDR_W = 4
) (
   // clock, reset, clock enable
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // engine status and handshakes
   input wire ucr_pkg::ucr_flags_t flags,
   input wire logic tx_data_load,
   input wire logic tx_data_moved,
   output ucr_pkg::ucr_clear_t flag_clear,
   output logic tx_empty_flag,
   // interrupt requests
   output ucr_pkg::ucr_irq_t irq,
   // configuration towards the engine
   output logic break_wait_enable,
   output logic [7:0] int_line_control,
   output logic [7:0] enable_speed_control,
   output logic [7:0] frame_control,
   output logic [3:0] data_bits,
   output logic nine_low_first,
   // line pins
   input wire logic rx_pin,
   input wire logic tx_line,
   output logic rx_to_receiver,
   output logic tx_pin_out,
   output logic tx_pin_oe
);
   import ucr_pkg::*;

   if (ADDR_W < 3) begin : g_bad_addr_w
      $error("ADDR_W too narrow for the register offsets");
   end

   logic rst_meta_reg;
   logic rst_sync_reg;
   ucr_state_t state_reg;
   ucr_state_t state_next;

   // reset release through two flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // address match against a register offset
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
      addr_is = (a == ADDR_W'(ofs));
   endfunction : addr_is

   // data bits per character
   function automatic logic [3:0] char_bits(input logic [2:0] code);
      unique case (code)
         3'h0: char_bits = 4'h5;
         3'h1: char_bits = 4'h6;
         3'h2: char_bits = 4'h7;
         3'h3: char_bits = 4'h8;
         UCR_CH_9_LOW_FIRST, UCR_CH_9_HIGH_FIRST: char_bits = 4'h9;
         default: char_bits = UCR_BITS_DEFAULT;
      endcase
   endfunction : char_bits

   // frame register as seen in the active layout
   function automatic logic [7:0] frame_view(input logic [7:0] fr);
      if (ucr_comm_mode_t'(fr[UCR_FR_COMM_MODE_LSB +: 2]) == UCR_CM_HOST_SPI) begin
         frame_view = fr & UCR_MASK_FRAME_SPI;
      end else begin
         frame_view = fr;
      end
   endfunction : frame_view

   always_comb begin
      state_next = state_reg;
      state_next.rdata = 8'h00;
      state_next.clear = '0;
      if (reg_write) begin
         if (addr_is(reg_addr, UCR_OFS_STATUS)) begin
            state_next.break_wait_enable = reg_wdata[UCR_ST_BREAK_WAIT];
            state_next.clear.tx_done_clear = reg_wdata[UCR_ST_TX_DONE];
            state_next.clear.rx_start_clear = reg_wdata[UCR_ST_RX_START];
            state_next.clear.bad_sync_clear = reg_wdata[UCR_ST_BAD_SYNC];
         end
         if (addr_is(reg_addr, UCR_OFS_INT_LINE)) begin
            state_next.int_line = reg_wdata & UCR_MASK_INT_LINE;
         end
         if (addr_is(reg_addr, UCR_OFS_ENA_SPEED)) begin
            state_next.ena_speed = reg_wdata & UCR_MASK_ENA_SPEED;
         end
         if (addr_is(reg_addr, UCR_OFS_FRAME)) begin
            if (ucr_comm_mode_t'(state_reg.frame[UCR_FR_COMM_MODE_LSB +: 2])
               == UCR_CM_HOST_SPI) begin
               // spi layout keeps the hidden normal fields untouched
               state_next.frame = (state_reg.frame & ~UCR_MASK_FRAME_SPI)
                  | (reg_wdata & UCR_MASK_FRAME_SPI);
            end else begin
               state_next.frame = reg_wdata;
            end
         end
      end
      if (reg_read) begin
         if (addr_is(reg_addr, UCR_OFS_STATUS)) begin
            state_next.rdata[UCR_ST_RX_DONE] = flags.rx_done_flag;
            state_next.rdata[UCR_ST_TX_DONE] = flags.tx_done_flag;
            state_next.rdata[UCR_ST_TX_EMPTY] = state_reg.tx_empty_flag;
            state_next.rdata[UCR_ST_RX_START] = flags.rx_start_flag;
            state_next.rdata[UCR_ST_BAD_SYNC] = flags.bad_sync_field_flag;
         end
         if (addr_is(reg_addr, UCR_OFS_INT_LINE)) begin
            state_next.rdata = state_reg.int_line;
         end
         if (addr_is(reg_addr, UCR_OFS_ENA_SPEED)) begin
            state_next.rdata = state_reg.ena_speed;
         end
         if (addr_is(reg_addr, UCR_OFS_FRAME)) begin
            state_next.rdata = frame_view(state_reg.frame);
         end
      end
      // empty flag: moving into the shifter wins over a load
      if (tx_data_moved) begin
         state_next.tx_empty_flag = 1'b1;
      end else if (tx_data_load) begin
         state_next.tx_empty_flag = 1'b0;
      end
      // requests: flag AND enable
      state_next.irq.rx_done_irq = flags.rx_done_flag
         & state_next.int_line[UCR_IL_RX_DONE_IE];
      state_next.irq.tx_done_irq = flags.tx_done_flag
         & state_next.int_line[UCR_IL_TX_DONE_IE];
      state_next.irq.tx_empty_irq = state_next.tx_empty_flag
         & state_next.int_line[UCR_IL_TX_EMPTY_IE];
      state_next.irq.rx_start_irq = flags.rx_start_flag
         & state_next.int_line[UCR_IL_RX_START_IE];
      state_next.irq.autobaud_error_irq = flags.bad_sync_field_flag
         & state_next.int_line[UCR_IL_AUTOBAUD_IE];
      // decoded character size
      state_next.data_bits = char_bits(state_next.frame[UCR_FR_CHAR_SIZE_LSB +: 3]);
      state_next.nine_low_first =
         (state_next.frame[UCR_FR_CHAR_SIZE_LSB +: 3] == UCR_CH_9_LOW_FIRST);
      // receiver input steering
      state_next.rx_to_receiver = state_next.int_line[UCR_IL_LOOPBACK]
         ? tx_line : rx_pin;
      // transmit pin: push-pull, or open-drain driving only low
      if (!state_next.ena_speed[UCR_EB_TRANSMITTER_ON]) begin
         state_next.tx_pin_out = 1'b1;
         state_next.tx_pin_oe = 1'b0;
      end else if (state_next.ena_speed[UCR_EB_OPEN_DRAIN]) begin
         state_next.tx_pin_out = 1'b0;
         state_next.tx_pin_oe = !tx_line;
      end else begin
         state_next.tx_pin_out = tx_line;
         state_next.tx_pin_oe = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.int_line <= UCR_RST_INT_LINE;
         state_reg.ena_speed <= UCR_RST_ENA_SPEED;
         state_reg.frame <= UCR_RST_FRAME;
         state_reg.tx_empty_flag <= 1'b1;
         state_reg.data_bits <= UCR_BITS_DEFAULT;
         state_reg.tx_pin_out <= 1'b1;
      end else if (!rst_sync_reg) begin
         state_reg <= '0;
         state_reg.int_line <= UCR_RST_INT_LINE;
         state_reg.ena_speed <= UCR_RST_ENA_SPEED;
         state_reg.frame <= UCR_RST_FRAME;
         state_reg.tx_empty_flag <= 1'b1;
         state_reg.data_bits <= UCR_BITS_DEFAULT;
         state_reg.tx_pin_out <= 1'b1;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata = state_reg.rdata;
   assign flag_clear = state_reg.clear;
   assign tx_empty_flag = state_reg.tx_empty_flag;
   assign irq = state_reg.irq;
   assign break_wait_enable = state_reg.break_wait_enable;
   assign int_line_control = state_reg.int_line;
   assign enable_speed_control = state_reg.ena_speed;
   assign frame_control = state_reg.frame;
   assign data_bits = state_reg.data_bits;
   assign nine_low_first = state_reg.nine_low_first;
   assign rx_to_receiver = state_reg.rx_to_receiver;
   assign tx_pin_out = state_reg.tx_pin_out;
   assign tx_pin_oe = state_reg.tx_pin_oe;

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_reg);

   a_irq_rx_gate: assert property (($past(clk_en) && $past(rst_sync_reg)) |->
      irq.rx_done_irq == ($past(flags.rx_done_flag) && int_line_control[UCR_IL_RX_DONE_IE]))
      else $error("receive-complete request not flag and enable");
   a_irq_tx_gate: assert property (($past(clk_en) && $past(rst_sync_reg)) |->
      irq.tx_done_irq == ($past(flags.tx_done_flag) && int_line_control[UCR_IL_TX_DONE_IE]))
      else $error("transmit-complete request not flag and enable");
   a_irq_empty_gate: assert property (
      irq.tx_empty_irq == (tx_empty_flag && int_line_control[UCR_IL_TX_EMPTY_IE]))
      else $error("empty request not flag and enable");
   a_irq_start_gate: assert property (($past(clk_en) && $past(rst_sync_reg)) |->
      irq.rx_start_irq == ($past(flags.rx_start_flag) && int_line_control[UCR_IL_RX_START_IE]))
      else $error("receive-start request not flag and enable");
   a_irq_baud_gate: assert property (($past(clk_en) && $past(rst_sync_reg)) |->
      irq.autobaud_error_irq ==
      ($past(flags.bad_sync_field_flag) && int_line_control[UCR_IL_AUTOBAUD_IE]))
      else $error("auto-baud request not flag and enable");
   a_loopback_path: assert property (($past(clk_en) && $past(rst_sync_reg)) |->
      rx_to_receiver ==
      (int_line_control[UCR_IL_LOOPBACK] ? $past(tx_line) : $past(rx_pin)))
      else $error("receiver input steered wrongly");
   a_open_drain_high: assert property (
      (enable_speed_control[UCR_EB_OPEN_DRAIN] && tx_pin_oe) |-> !tx_pin_out)
      else $error("open drain drove high");
   a_tx_off_float: assert property (
      !enable_speed_control[UCR_EB_TRANSMITTER_ON] |-> !tx_pin_oe)
      else $error("transmit pin driven while transmitter off");
   a_empty_moved: assert property ((clk_en && tx_data_moved) |=> tx_empty_flag)
      else $error("empty flag not set after move");
   a_empty_loaded: assert property (
      (clk_en && tx_data_load && !tx_data_moved) |=> !tx_empty_flag)
      else $error("empty flag not cleared after load");
   a_wait_break_wr: assert property (
      (clk_en && reg_write && addr_is(reg_addr, UCR_OFS_STATUS))
      |=> break_wait_enable == $past(reg_wdata[UCR_ST_BREAK_WAIT]))
      else $error("break wait bit not stored");
   a_ctrl_a_rsvd: assert property (!int_line_control[1])
      else $error("reserved control bit set");
   a_ctrl_b_rsvd: assert property (!enable_speed_control[5])
      else $error("reserved enable bit set");
   a_spi_layout: assert property ((clk_en && reg_read && addr_is(reg_addr, UCR_OFS_FRAME)
      && frame_control[UCR_FR_COMM_MODE_LSB +: 2] == 2'h3)
      |=> (reg_rdata & ~UCR_MASK_FRAME_SPI) == 8'h00)
      else $error("host spi layout shows normal fields");
   a_frame_wr_rd: assert property (
      (clk_en && reg_write && addr_is(reg_addr, UCR_OFS_FRAME)
      && frame_control[UCR_FR_COMM_MODE_LSB +: 2] != 2'h3) |=> frame_control == $past(reg_wdata))
      else $error("frame register not written");
   a_size_nine: assert property (frame_control[2:1] == 2'h3 |-> data_bits == 4'h9)
      else $error("nine bit size not decoded");
   a_read_once: assert property ((clk_en && !reg_read) |=> reg_rdata == 8'h00)
      else $error("read data stands outside its cycle");

   c_loopback_on: cover property (int_line_control[UCR_IL_LOOPBACK] && rx_to_receiver != rx_pin);
   c_spi_mode: cover property (frame_control[UCR_FR_COMM_MODE_LSB +: 2] == 2'h3);
   c_irq_rx: cover property (irq.rx_done_irq);
   c_open_drain: cover property (enable_speed_control[UCR_EB_OPEN_DRAIN] && tx_pin_oe);
endmodule : ucr_usart_control_regs

// ===== hw/ucr_pkg.sv
// ucr_pkg: constants and types of the serial transceiver control register bank
package ucr_pkg;
   // register offsets (byte wide registers)
   localparam logic [3:0] UCR_OFS_STATUS = 4'h4;
   localparam logic [3:0] UCR_OFS_INT_LINE = 4'h5;
   localparam logic [3:0] UCR_OFS_ENA_SPEED = 4'h6;
   localparam logic [3:0] UCR_OFS_FRAME = 4'h7;
   // reset values
   localparam logic [7:0] UCR_RST_INT_LINE = 8'h00;
   localparam logic [7:0] UCR_RST_ENA_SPEED = 8'h00;
   localparam logic [7:0] UCR_RST_FRAME = 8'h03;
   // writable bit masks
   localparam logic [7:0] UCR_MASK_INT_LINE = 8'hFD;
   localparam logic [7:0] UCR_MASK_ENA_SPEED = 8'hDF;
   localparam logic [7:0] UCR_MASK_FRAME_SPI = 8'hC6;
   // status register bits
   localparam int UCR_ST_RX_DONE = 7;
   localparam int UCR_ST_TX_DONE = 6;
   localparam int UCR_ST_TX_EMPTY = 5;
   localparam int UCR_ST_RX_START = 4;
   localparam int UCR_ST_BAD_SYNC = 3;
   localparam int UCR_ST_BREAK_WAIT = 0;
   // interrupt and line control bits
   localparam int UCR_IL_RX_DONE_IE = 7;
   localparam int UCR_IL_TX_DONE_IE = 6;
   localparam int UCR_IL_TX_EMPTY_IE = 5;
   localparam int UCR_IL_RX_START_IE = 4;
   localparam int UCR_IL_LOOPBACK = 3;
   localparam int UCR_IL_AUTOBAUD_IE = 2;
   localparam int UCR_IL_RS485 = 0;
   // enable and receiver mode bits
   localparam int UCR_EB_RECEIVER_ON = 7;
   localparam int UCR_EB_TRANSMITTER_ON = 6;
   localparam int UCR_EB_FRAME_START_DET = 4;
   localparam int UCR_EB_OPEN_DRAIN = 3;
   localparam int UCR_EB_SPEED_LSB = 1;
   localparam int UCR_EB_MULTIPROC = 0;
   // frame format fields
   localparam int UCR_FR_COMM_MODE_LSB = 6;
   localparam int UCR_FR_PARITY_LSB = 4;
   localparam int UCR_FR_STOP = 3;
   localparam int UCR_FR_CHAR_SIZE_LSB = 0;
   localparam int UCR_FR_DATA_ORDER = 2;
   localparam int UCR_FR_CLOCK_PHASE = 1;
   typedef enum logic [1:0] {
      UCR_RX_NORMAL, UCR_RX_DOUBLE_SPEED, UCR_RX_GENERIC_AUTOBAUD, UCR_RX_LIN_AUTOBAUD
   } ucr_speed_mode_t;
   typedef enum logic [1:0] {
      UCR_CM_ASYNC, UCR_CM_SYNC, UCR_CM_INFRARED, UCR_CM_HOST_SPI
   } ucr_comm_mode_t;
   localparam logic [2:0] UCR_CH_9_LOW_FIRST = 3'h6;
   localparam logic [2:0] UCR_CH_9_HIGH_FIRST = 3'h7;
   localparam logic [3:0] UCR_BITS_DEFAULT = 4'h8;
   // engine status flags
   typedef struct packed {
      logic rx_done_flag;
      logic tx_done_flag;
      logic rx_start_flag;
      logic bad_sync_field_flag;
   } ucr_flags_t;
   // flag clear pulses towards the engine
   typedef struct packed {
      logic tx_done_clear;
      logic rx_start_clear;
      logic bad_sync_clear;
   } ucr_clear_t;
   // interrupt requests
   typedef struct packed {
      logic rx_done_irq;
      logic tx_done_irq;
      logic tx_empty_irq;
      logic rx_start_irq;
      logic autobaud_error_irq;
   } ucr_irq_t;
   // whole register state
   typedef struct packed {
      logic [7:0] int_line;
      logic [7:0] ena_speed;
      logic [7:0] frame;
      logic break_wait_enable;
      logic tx_empty_flag;
      logic [7:0] rdata;
      ucr_clear_t clear;
      ucr_irq_t irq;
      logic [3:0] data_bits;
      logic nine_low_first;
      logic rx_to_receiver;
      logic tx_pin_out;
      logic tx_pin_oe;
   } ucr_state_t;
endpackage : ucr_pkg

// ===== test/ucr_remote_node.sv
// ucr_remote_node: far-side serial node model on the transmit and receive lines
`timescale 1ns/10ps
module ucr_remote_node (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // bench command
   input wire logic node_bit,
   // line pins
   input wire logic tx_pin_out,
   input wire logic tx_pin_oe,
   output logic rx_pin,
   output logic line_level
);
   // pulled-up single wire: a released pin reads high
   assign line_level = tx_pin_oe ? tx_pin_out : 1'b1;
   // node drives its own line bit by bit, changed only after a clock edge
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rx_pin <= 1'b1;
      end else begin
         rx_pin <= node_bit;
      end
   end
endmodule : ucr_remote_node

// ===== test/ucr_usart_control_regs_tb.sv
// ucr_usart_control_regs_tb: register and line checks of the control register bank
`timescale 1ns/10ps
module ucr_usart_control_regs_tb;
   import ucr_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   ucr_flags_t flags = '0;
   logic tx_data_load = 1'b0;
   logic tx_data_moved = 1'b0;
   logic tx_empty_flag;
   ucr_irq_t irq;
   logic break_wait_enable;
   logic [7:0] int_line_control;
   logic [7:0] enable_speed_control;
   logic clk_en = 1'b1;
   ucr_clear_t flag_clear;
   logic [7:0] frame_control;
   logic [3:0] data_bits;
   logic nine_low_first;
   logic rx_pin;
   logic tx_line = 1'b1;
   logic rx_to_receiver;
   logic tx_pin_out;
   logic tx_pin_oe;
   logic node_bit = 1'b1;
   logic line_level;
   int num_errors = 0;
   int comparisons = 0;
   always #10 clock = ~clock;
   ucr_usart_control_regs #(.ADDR_W(4)) i_dut (
      .clock(clock), .reset_n(reset_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata),
      .flags(flags), .tx_data_load(tx_data_load), .tx_data_moved(tx_data_moved),
      .flag_clear(flag_clear), .tx_empty_flag(tx_empty_flag), .irq(irq),
      .break_wait_enable(break_wait_enable), .int_line_control(int_line_control),
      .enable_speed_control(enable_speed_control), .frame_control(frame_control),
      .data_bits(data_bits), .nine_low_first(nine_low_first),
      .rx_pin(rx_pin), .tx_line(tx_line), .rx_to_receiver(rx_to_receiver),
      .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe)
   );
   ucr_remote_node i_node (
      .clock(clock), .reset_n(reset_n), .node_bit(node_bit),
      .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
      .rx_pin(rx_pin), .line_level(line_level)
   );
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask : rd_chk
   task automatic settle;
      repeat (4) @(posedge clock);
      #1;
   endtask : settle
   initial begin
      #200000;
      num_errors++;
      $display("unexpected at %0t: run did not end", $time);
      report_and_stop();
   end
   initial begin
      logic [3:0] bits_tab [8];
      int en_bit [5];
      bits_tab = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h8, 4'h9, 4'h9};
      en_bit = '{7, 6, 5, 4, 2};
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      // reset values
      rd_chk(4'h5, 8'h00);
      rd_chk(4'h6, 8'h00);
      rd_chk(4'h7, 8'h03);
      check({4'h0, data_bits}, 8'h08);
      check({7'h0, tx_empty_flag}, 8'h01);
      // reserved bits and unmapped place
      wr(4'h5, 8'hFF);
      rd_chk(4'h5, 8'hFD);
      check(int_line_control, 8'hFD);
      rd_chk(4'h9, 8'h00);
      // a write while the clock enable is low is lost
      clk_en <= 1'b0;
      wr(4'h5, 8'h00);
      clk_en <= 1'b1;
      #1;
      check(int_line_control, 8'hFD);
      // one enable at a time with every flag raised
      flags <= '1;
      rd_chk(4'h4, 8'hF8);
      for (int k = 0; k < 5; k++) begin
         wr(4'h5, 8'h01 << en_bit[k]);
         settle();
         check({3'h0, irq}, 8'h10 >> k);
      end
      // all enabled, flags dropped: only the empty request remains
      flags <= '0;
      wr(4'h5, 8'hF4);
      settle();
      check({3'h0, irq}, 8'h04);
      @(posedge clock);
      tx_data_load <= 1'b1;
      @(posedge clock);
      tx_data_load <= 1'b0;
      settle();
      check({6'h0, tx_empty_flag, irq.tx_empty_irq}, 8'h00);
      tx_data_load <= 1'b1;
      tx_data_moved <= 1'b1;
      @(posedge clock);
      tx_data_load <= 1'b0;
      tx_data_moved <= 1'b0;
      settle();
      check({6'h0, tx_empty_flag, irq.tx_empty_irq}, 8'h03);
      // loop-back steering
      node_bit <= 1'b1;
      tx_line <= 1'b0;
      wr(4'h5, 8'h08);
      settle();
      check({7'h0, rx_to_receiver}, 8'h00);
      wr(4'h5, 8'h00);
      settle();
      check({7'h0, rx_to_receiver}, 8'h01);
      node_bit <= 1'b0;
      settle();
      check({7'h0, rx_to_receiver}, 8'h00);
      // receiver speed codes with all other control bits set, synchronous mode
      wr(4'h7, 8'h43);
      for (int m = 0; m < 4; m++) begin
         wr(4'h6, 8'hD9 | 8'(m << 1));
         rd_chk(4'h6, 8'hD9 | 8'(m << 1));
      end
      // open drain, push-pull and released transmit pin
      wr(4'h6, 8'h48);
      tx_line <= 1'b0;
      settle();
      check({6'h0, tx_pin_oe, tx_pin_out}, 8'h02);
      tx_line <= 1'b1;
      settle();
      check({6'h0, tx_pin_oe, line_level}, 8'h01);
      wr(4'h6, 8'h40);
      settle();
      check({6'h0, tx_pin_oe, tx_pin_out}, 8'h03);
      wr(4'h6, 8'h00);
      settle();
      check({7'h0, tx_pin_oe}, 8'h00);
      // communication modes, host SPI layout and its exit
      for (int k = 0; k < 4; k++) begin
         wr(4'h7, {k[1:0], 6'h2B});
         rd_chk(4'h7, (k == 3) ? 8'hC2 : {k[1:0], 6'h2B});
      end
      wr(4'h7, 8'h03);
      #1;
      check(frame_control, 8'h2B);
      wr(4'h7, 8'h03);
      rd_chk(4'h7, 8'h03);
      // character size codes
      for (int c = 0; c < 8; c++) begin
         wr(4'h7, {5'h00, 3'(c)});
         settle();
         check({3'h0, nine_low_first, data_bits}, {3'h0, c == 6, bits_tab[c]});
      end
      // wait-for-break enable and one-cycle flag clear pulses
      wr(4'h4, 8'h59);
      #1;
      check({4'h0, flag_clear, break_wait_enable}, 8'h0F);
      settle();
      check({4'h0, flag_clear, break_wait_enable}, 8'h01);
      wr(4'h4, 8'h00);
      settle();
      check({7'h0, break_wait_enable}, 8'h00);
      // second reset in mid-run clears both control registers
      wr(4'h5, 8'hFD);
      wr(4'h6, 8'h59);
      reset_n <= 1'b0;
      @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      rd_chk(4'h5, 8'h00);
      rd_chk(4'h6, 8'h00);
      rd_chk(4'h7, 8'h03);
      report_and_stop();
   end
endmodule : ucr_usart_control_regs_tb
